// ---- rtl/flag_mask_pkg.sv ----
/*
 * Shared constants and types for the module flag, mask and interrupt block:
 * register offsets, field positions, reset values and timing figures.
 * Assumes a 100 MHz block clock; times are kept in their own units.
 */
package flag_mask_pkg;

    // Block clock rate
    localparam int CLK_HZ = 100_000_000;

    // Register byte offsets on the AXI4-Lite port
    localparam logic [7:0] FLAGS_OFFSET   = 8'h00;
    localparam logic [7:0] MASK_OFFSET    = 8'h04;
    localparam logic [7:0] CONTROL_OFFSET = 8'h08;
    localparam logic [7:0] LIVE_OFFSET    = 8'h0C;

    // Flag layout: bit 0 transmit fault, bit 1 receive loss, rest other monitors
    localparam int FLAG_W      = 6;
    localparam int TX_FAULT_BIT = 0;
    localparam int RX_LOS_BIT   = 1;
    localparam int OTHER_LSB    = 2;

    // Reset values
    localparam logic [FLAG_W-1:0] MASK_RESET    = 6'h00;
    localparam logic [2:0]        CONTROL_RESET = 3'h0;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Timing limits, as printed, and their cycle counts (all exact at 100 MHz, none round)
    localparam int LOS_FAST_OFF_MS = 3;
    localparam int INT_ON_MS       = 200;
    localparam int LOS_ON_MS       = 100;
    localparam int MASK_MS         = 100;
    localparam int RATESEL_MS      = 100;
    localparam int INT_OFF_US      = 500;
    localparam int LOS_FAST_OFF_CYC = LOS_FAST_OFF_MS * (CLK_HZ / 1000);
    localparam int INT_ON_CYC       = INT_ON_MS * (CLK_HZ / 1000);
    localparam int LOS_ON_CYC       = LOS_ON_MS * (CLK_HZ / 1000);
    localparam int MASK_CYC         = MASK_MS * (CLK_HZ / 1000);
    localparam int RATESEL_CYC      = RATESEL_MS * (CLK_HZ / 1000);
    localparam int INT_OFF_CYC      = INT_OFF_US * (CLK_HZ / 1000_000);

    // Control field, software written, applied at the next stop condition
    typedef struct packed {
        logic app_sel;
        logic rate_sel;
        logic fast_los;
    } control_type;

    // Sampled two-wire pins
    typedef struct packed {
        logic scl;
        logic sda;
    } wire_pair_type;

endpackage : flag_mask_pkg

// ---- rtl/module_flag_mask_timing.sv ----
/*
 * Latched flag, mask and interrupt logic of a pluggable module's management
 * side, with an AXI4-Lite register port and a watcher on the two-wire pins.
 * Assumes monitor inputs and the two-wire pins are asynchronous to aclk and
 * that the register port carries the two-wire host's accesses.
 */
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
// Notes on behaviour
// - In fast loss mode, loss status clears within 3 ms of signal return.
// - Transmit fault sets its flag and asserts the interrupt within 200 ms.
// - Any other monitored condition sets its flag and interrupt within 200 ms.
// - Setting a mask bit inhibits that flag's interrupt within 100 ms.
// - Clearing a mask bit restores that flag's interrupt within 100 ms.
// - Application or rate select changes take effect within 100 ms.
// - Write-triggered bounds start at the stop condition ending the write.
// - Read-triggered bounds start at the stop condition ending the read.
// - Flags clear on read; interrupt releases within 500 us after it.
// - Normal mode loss of signal sets flag and interrupt within 100 ms.
`timescale 1ns/100ps
module module_flag_mask_timing #(
    parameter int INT_ON_LIMIT  = flag_mask_pkg::INT_ON_CYC,
    parameter int INT_OFF_LIMIT = flag_mask_pkg::INT_OFF_CYC
) (
    input  wire logic                              aclk,
    input  wire logic                              aresetn,
    input  wire logic [7:0]                        s_axi_awaddr,
    input  wire logic                              s_axi_awvalid,
    output logic                                   s_axi_awready,
    input  wire logic [31:0]                       s_axi_wdata,
    input  wire logic [3:0]                        s_axi_wstrb,
    input  wire logic                              s_axi_wvalid,
    output logic                                   s_axi_wready,
    output logic [1:0]                             s_axi_bresp,
    output logic                                   s_axi_bvalid,
    input  wire logic                              s_axi_bready,
    input  wire logic [7:0]                        s_axi_araddr,
    input  wire logic                              s_axi_arvalid,
    output logic                                   s_axi_arready,
    output logic [31:0]                            s_axi_rdata,
    output logic [1:0]                             s_axi_rresp,
    output logic                                   s_axi_rvalid,
    input  wire logic                              s_axi_rready,
    input  wire logic                              scl_in,
    input  wire logic                              sda_in,
    input  wire logic                              tx_fault_in,
    input  wire logic                              rx_los_in,
    input  wire logic [flag_mask_pkg::FLAG_W-3:0]  other_cond_in,
    output logic                                   rx_los_status,
    output flag_mask_pkg::control_type             control_out,
    output logic                                   interrupt_request_n,
    output logic                                   irq
);
    import flag_mask_pkg::*;

    // Two-flop synchronisers; stage one feeds stage two only
    logic [FLAG_W-1:0] cond_meta_ff, cond_sync_ff;
    wire_pair_type     pin_meta_ff, pin_sync_ff, pin_prev_ff;
    logic              stop_seen;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cond_meta_ff <= '0;
            cond_sync_ff <= '0;
            pin_meta_ff  <= '1;
            pin_sync_ff  <= '1;
            pin_prev_ff  <= '1;
        end else begin
            cond_meta_ff <= {other_cond_in, rx_los_in, tx_fault_in};
            cond_sync_ff <= cond_meta_ff;
            pin_meta_ff  <= '{scl: scl_in, sda: sda_in};
            pin_sync_ff  <= pin_meta_ff;
            pin_prev_ff  <= pin_sync_ff;
        end
    end

    // Stop condition: data rises while clock is high
    assign stop_seen = pin_sync_ff.scl & pin_prev_ff.scl & pin_sync_ff.sda & ~pin_prev_ff.sda;

    // AXI write channel holding registers
    logic              aw_hold_ff, nxt_aw_hold;
    logic              w_hold_ff, nxt_w_hold;
    logic [7:0]        awaddr_ff, nxt_awaddr;
    logic [31:0]       wdata_ff, nxt_wdata;
    logic              bvalid_ff, nxt_bvalid;
    logic [1:0]        bresp_ff, nxt_bresp;
    logic              do_write;

    // AXI read channel registers
    logic              rvalid_ff, nxt_rvalid;
    logic [31:0]       rdata_ff, nxt_rdata;
    logic [1:0]        rresp_ff, nxt_rresp;

    // Block state
    logic [FLAG_W-1:0] flags_ff, nxt_flags;
    logic [FLAG_W-1:0] mask_ff, nxt_mask;
    logic [FLAG_W-1:0] mask_stage_ff, nxt_mask_stage;
    logic [FLAG_W-1:0] clr_pend_ff, nxt_clr_pend;
    control_type       ctrl_ff, nxt_ctrl;
    control_type       ctrl_stage_ff, nxt_ctrl_stage;
    logic              irq_n_ff, nxt_irq_n;
    logic [FLAG_W-1:0] flag_set;

    assign s_axi_awready = ~aw_hold_ff;
    assign s_axi_wready  = ~w_hold_ff;
    assign s_axi_arready = ~rvalid_ff;
    assign do_write      = aw_hold_ff & w_hold_ff & ~bvalid_ff;

    // Flag set sources; loss of signal latches in either loss mode
    always_comb begin
        flag_set = cond_sync_ff;
    end

    // Register port: address and data taken in either order, answer follows both
    always_comb begin
        nxt_aw_hold = aw_hold_ff;
        nxt_w_hold  = w_hold_ff;
        nxt_awaddr  = awaddr_ff;
        nxt_wdata   = wdata_ff;
        nxt_bvalid  = bvalid_ff;
        nxt_bresp   = bresp_ff;
        nxt_rvalid  = rvalid_ff;
        nxt_rdata   = rdata_ff;
        nxt_rresp   = rresp_ff;
        if (s_axi_awvalid && !aw_hold_ff) begin
            nxt_aw_hold = 1'b1;
            nxt_awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_hold_ff) begin
            nxt_w_hold = 1'b1;
            nxt_wdata  = s_axi_wdata;
        end
        if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
        if (do_write) begin
            nxt_aw_hold = 1'b0;
            nxt_w_hold  = 1'b0;
            nxt_bvalid  = 1'b1;
            if ({awaddr_ff[7:2], 2'b00} == FLAGS_OFFSET || {awaddr_ff[7:2], 2'b00} == MASK_OFFSET
                || {awaddr_ff[7:2], 2'b00} == CONTROL_OFFSET) begin
                nxt_bresp = RESP_OKAY;
            end else begin
                nxt_bresp = RESP_SLVERR;
            end
        end
        if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
        if (s_axi_arvalid && !rvalid_ff) begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = RESP_OKAY;
            if ({s_axi_araddr[7:2], 2'b00} == FLAGS_OFFSET) begin
                nxt_rdata = {{(32-FLAG_W){1'b0}}, flags_ff};
            end else if ({s_axi_araddr[7:2], 2'b00} == MASK_OFFSET) begin
                nxt_rdata = {{(32-FLAG_W){1'b0}}, mask_stage_ff};
            end else if ({s_axi_araddr[7:2], 2'b00} == CONTROL_OFFSET) begin
                nxt_rdata = {29'h0000000, ctrl_stage_ff};
            end else if ({s_axi_araddr[7:2], 2'b00} == LIVE_OFFSET) begin
                nxt_rdata = {16'h0000, 2'b00, mask_ff, 2'b00, cond_sync_ff};
            end else begin
                nxt_rdata = 32'h00000000;
                nxt_rresp = RESP_SLVERR;
            end
        end
    end

    // Staging, clear-on-read and stop-condition commit.
    // Software changes wait for the stop that ends the transaction, so every
    // bound starts from one well-defined point; set always beats a clear.
    always_comb begin
        logic [FLAG_W-1:0] clr_now;
        clr_now        = '0;
        nxt_flags      = flags_ff;
        nxt_mask       = mask_ff;
        nxt_mask_stage = mask_stage_ff;
        nxt_ctrl       = ctrl_ff;
        nxt_ctrl_stage = ctrl_stage_ff;
        nxt_clr_pend   = clr_pend_ff;
        if (s_axi_arvalid && !rvalid_ff && {s_axi_araddr[7:2], 2'b00} == FLAGS_OFFSET) begin
            nxt_clr_pend = nxt_clr_pend | flags_ff;
        end
        if (do_write && s_axi_wstrb[0]) begin
            if ({awaddr_ff[7:2], 2'b00} == FLAGS_OFFSET) begin
                nxt_clr_pend = nxt_clr_pend | wdata_ff[FLAG_W-1:0];
            end else if ({awaddr_ff[7:2], 2'b00} == MASK_OFFSET) begin
                nxt_mask_stage = wdata_ff[FLAG_W-1:0];
            end else if ({awaddr_ff[7:2], 2'b00} == CONTROL_OFFSET) begin
                nxt_ctrl_stage = control_type'(wdata_ff[2:0]);
            end
        end
        if (stop_seen) begin
            clr_now      = clr_pend_ff;
            nxt_clr_pend = nxt_clr_pend & ~clr_pend_ff;
            nxt_mask     = mask_stage_ff;
            nxt_ctrl     = ctrl_stage_ff;
        end
        nxt_flags = (flags_ff & ~clr_now) | flag_set;
    end

    // Interrupt line: low while any unmasked flag stands
    always_comb begin
        nxt_irq_n = ~|(nxt_flags & ~nxt_mask);
    end

    // State registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_ff    <= 1'b0;
            w_hold_ff     <= 1'b0;
            awaddr_ff     <= 8'h00;
            wdata_ff      <= 32'h00000000;
            bvalid_ff     <= 1'b0;
            bresp_ff      <= RESP_OKAY;
            rvalid_ff     <= 1'b0;
            rdata_ff      <= 32'h00000000;
            rresp_ff      <= RESP_OKAY;
            flags_ff      <= '0;
            mask_ff       <= MASK_RESET;
            mask_stage_ff <= MASK_RESET;
            clr_pend_ff   <= '0;
            ctrl_ff       <= CONTROL_RESET;
            ctrl_stage_ff <= CONTROL_RESET;
            irq_n_ff      <= 1'b1;
        end else begin
            aw_hold_ff    <= nxt_aw_hold;
            w_hold_ff     <= nxt_w_hold;
            awaddr_ff     <= nxt_awaddr;
            wdata_ff      <= nxt_wdata;
            bvalid_ff     <= nxt_bvalid;
            bresp_ff      <= nxt_bresp;
            rvalid_ff     <= nxt_rvalid;
            rdata_ff      <= nxt_rdata;
            rresp_ff      <= nxt_rresp;
            flags_ff      <= nxt_flags;
            mask_ff       <= nxt_mask;
            mask_stage_ff <= nxt_mask_stage;
            clr_pend_ff   <= nxt_clr_pend;
            ctrl_ff       <= nxt_ctrl;
            ctrl_stage_ff <= nxt_ctrl_stage;
            irq_n_ff      <= nxt_irq_n;
        end
    end

    assign s_axi_bvalid        = bvalid_ff;
    assign s_axi_bresp         = bresp_ff;
    assign s_axi_rvalid        = rvalid_ff;
    assign s_axi_rdata         = rdata_ff;
    assign s_axi_rresp         = rresp_ff;
    assign interrupt_request_n = irq_n_ff;
    assign irq                 = ~irq_n_ff;
    assign control_out         = ctrl_ff;
    // Live loss status follows the input in both modes, far inside the fast bound
    assign rx_los_status       = cond_sync_ff[RX_LOS_BIT];

    // Helper: cycles that an unmasked flag has stood with the line still high
    logic [31:0] late_on_cnt_ff, nxt_late_on_cnt;
    always_comb begin
        nxt_late_on_cnt = (|(flags_ff & ~mask_ff) && irq_n_ff) ? late_on_cnt_ff + 32'h00000001 : 32'h00000000;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            late_on_cnt_ff <= 32'h00000000;
        end else begin
            late_on_cnt_ff <= nxt_late_on_cnt;
        end
    end

    property p_tx_fault_flag;
        @(posedge aclk) disable iff (!aresetn)
        cond_sync_ff[TX_FAULT_BIT] |=> flags_ff[TX_FAULT_BIT];
    endproperty
    a_tx_fault_flag: assert property (p_tx_fault_flag) else $error("tx fault flag not set");

    property p_other_flag;
        @(posedge aclk) disable iff (!aresetn)
        $rose(cond_sync_ff[OTHER_LSB]) |=> flags_ff[OTHER_LSB] ##1 flags_ff[OTHER_LSB];
    endproperty
    a_other_flag: assert property (p_other_flag) else $error("monitor flag not latched");

    property p_los_flag;
        @(posedge aclk) disable iff (!aresetn)
        cond_sync_ff[RX_LOS_BIT] && !mask_ff[RX_LOS_BIT] && !nxt_mask[RX_LOS_BIT] |=> ##1 !interrupt_request_n;
    endproperty
    a_los_flag: assert property (p_los_flag) else $error("loss interrupt late");

    property p_los_status;
        @(posedge aclk) disable iff (!aresetn)
        $fell(cond_sync_ff[RX_LOS_BIT]) |-> !rx_los_status;
    endproperty
    a_los_status: assert property (p_los_status) else $error("loss status stuck");

    property p_mask_commit;
        @(posedge aclk) disable iff (!aresetn)
        stop_seen |=> mask_ff == $past(mask_stage_ff) && control_out == $past(ctrl_stage_ff);
    endproperty
    a_mask_commit: assert property (p_mask_commit) else $error("mask or select not applied at stop");

    property p_mask_hold;
        @(posedge aclk) disable iff (!aresetn)
        !stop_seen |=> $stable(mask_ff) && $stable(control_out);
    endproperty
    a_mask_hold: assert property (p_mask_hold) else $error("mask changed without stop");

    property p_read_clear;
        @(posedge aclk) disable iff (!aresetn)
        stop_seen && clr_pend_ff != '0 && (cond_sync_ff & clr_pend_ff) == '0
        |=> (flags_ff & $past(clr_pend_ff)) == '0;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("flag not cleared at stop");

    property p_release;
        @(posedge aclk) disable iff (!aresetn)
        stop_seen && clr_pend_ff != '0 && (((flags_ff & ~clr_pend_ff) | cond_sync_ff) & ~mask_stage_ff) == '0
        |=> interrupt_request_n;
    endproperty
    a_release: assert property (p_release) else $error("interrupt not released");

    property p_unmask_assert;
        @(posedge aclk) disable iff (!aresetn)
        late_on_cnt_ff > 1 |-> late_on_cnt_ff < INT_ON_LIMIT;
    endproperty
    a_unmask_assert: assert property (p_unmask_assert) else $error("unmasked flag without interrupt");

    property p_level;
        @(posedge aclk) disable iff (!aresetn)
        ##1 interrupt_request_n == !(|($past(nxt_flags) & $past(nxt_mask) ^ $past(nxt_flags)));
    endproperty
    a_level: assert property (p_level) else $error("interrupt level wrong");

    property p_select_stage;
        @(posedge aclk) disable iff (!aresetn)
        stop_seen && ctrl_stage_ff != control_out |=> $changed(control_out);
    endproperty
    a_select_stage: assert property (p_select_stage) else $error("select change lost");

endmodule : module_flag_mask_timing

// ---- tb/host_wire_model.sv ----
/*
 * Behavioural host on the two-wire management pins: sends a short frame
 * that ends in a stop condition, which commits the block's staged writes.
 * Assumes both lines have pull-ups and that the bench starts frames one at a time.
 */
`timescale 1ns/100ps
module host_wire_model (
    input  wire logic frame_go,
    output logic      scl,
    output logic      sda,
    output logic      frame_busy
);
    localparam time HALF = 40;

    // Lines idle high on their pull-ups; the clock stands still between frames
    initial begin
        scl = 1'b1;
        sda = 1'b1;
        frame_busy = 1'b0;
    end

    // Start, one bit, then stop; skewed so the pins are unrelated to aclk
    always @(posedge frame_go) begin
        frame_busy = 1'b1;
        #7;
        sda = 1'b0;
        #HALF scl = 1'b0;
        #HALF scl = 1'b1;
        #HALF scl = 1'b0;
        #HALF scl = 1'b1;
        #HALF sda = 1'b1; // Data rises while clock high
        #HALF frame_busy = 1'b0;
    end
endmodule : host_wire_model

// ---- tb/module_flag_mask_timing_test.sv ----
/*
 * Self-checking bench for the flag, mask and interrupt block: AXI4-Lite
 * tasks, monitored conditions, and stop conditions from the wire model.
 * Assumes the design commits staged values only at a stop on the pins.
 */
`timescale 1ns/100ps
`define CHECK(got, exp) begin compares++; if ((got) !== (exp)) begin err_count++; \
    $display("[FAIL] %0t got %0h expected %0h", $time, (got), (exp)); end end
module module_flag_mask_timing_test;
    import flag_mask_pkg::*;
    localparam int ON_LIM  = 100;
    localparam int OFF_LIM = 50;

    logic        aclk, aresetn, frame_go, frame_busy, scl, sda;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, rx_los_status, interrupt_request_n, irq;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic [5:0]  cond;
    logic [2:0]  ctl;
    control_type control_out;
    int          err_count, compares, i, n;

    module_flag_mask_timing #(.INT_ON_LIMIT(ON_LIM), .INT_OFF_LIMIT(OFF_LIM)) dut_u (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .scl_in(scl), .sda_in(sda),
        .tx_fault_in(cond[0]), .rx_los_in(cond[1]), .other_cond_in(cond[5:2]),
        .rx_los_status(rx_los_status), .control_out(control_out),
        .interrupt_request_n(interrupt_request_n), .irq(irq)
    );

    host_wire_model wire_u (.frame_go(frame_go), .scl(scl), .sda(sda), .frame_busy(frame_busy));

    // 100 MHz block clock
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // Whole run is far shorter; a hang counts as a mismatch
    initial begin
        #300_000;
        err_count++;
        report_and_stop();
    end

    task automatic report_and_stop;
        $display("Mismatches %0d, comparisons %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    // Address and data offered together; each released once taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_hs, w_hs, b_hs;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            #1;
            aw_hs = s_axi_awvalid && s_axi_awready;
            w_hs = s_axi_wvalid && s_axi_wready;
            b_hs = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (aw_hs) s_axi_awvalid <= 1'b0;
            if (w_hs) s_axi_wvalid <= 1'b0;
        end while (!b_hs);
        s_axi_bready <= 1'b0;
        `CHECK(b_hs, 1'b1);
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_hs, r_hs;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            #1;
            ar_hs = s_axi_arvalid && s_axi_arready;
            r_hs = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ar_hs) s_axi_arvalid <= 1'b0;
        end while (!r_hs);
        s_axi_rready <= 1'b0;
        `CHECK(r_hs, 1'b1);
    endtask : axi_read

    // One frame on the pins, ending in the stop that commits staged work
    task automatic do_stop;
        @(posedge aclk);
        frame_go <= 1'b1;
        @(posedge aclk);
        frame_go <= 1'b0;
        #1;
        while (frame_busy) begin
            @(posedge aclk);
            #1;
        end
    endtask : do_stop

    // Bounded wait for the interrupt line to reach a level
    task automatic wait_int(input logic exp);
        int k;
        k = 0;
        @(posedge aclk);
        #1;
        while (interrupt_request_n !== exp && k < ON_LIM) begin
            @(posedge aclk);
            #1;
            k++;
        end
        `CHECK(interrupt_request_n, exp);
        `CHECK(irq, ~exp);
    endtask : wait_int

    // Line must hold its level while nothing is committed
    task automatic hold_int(input logic exp);
        repeat (20) @(posedge aclk);
        #1;
        `CHECK(interrupt_request_n, exp);
    endtask : hold_int

    initial begin
        {aresetn, frame_go, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        cond = 6'h00;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset state, register defaults, unmapped place
        @(posedge aclk);
        #1;
        `CHECK(interrupt_request_n, 1'b1);
        `CHECK(control_out, CONTROL_RESET);
        axi_read(MASK_OFFSET, rd, rs);
        `CHECK(rd[5:0], MASK_RESET);
        axi_read(8'h10, rd, rs);
        `CHECK(rs, RESP_SLVERR);
        `CHECK(rd, 32'h0000_0000);
        axi_write(8'h14, 32'h0000_003F, rs);
        `CHECK(rs, RESP_SLVERR);
        // Every flag: latch, interrupt, clear on read only once the stop is seen
        for (i = 0; i < FLAG_W; i++) begin
            @(posedge aclk);
            cond <= 6'(1 << i);
            wait_int(1'b0);
            if (i == RX_LOS_BIT) `CHECK(rx_los_status, 1'b1);
            @(posedge aclk);
            cond <= 6'h00;
            axi_read(FLAGS_OFFSET, rd, rs);
            `CHECK(rd[5:0], 6'(1 << i));
            hold_int(1'b0);
            do_stop();
            wait_int(1'b1);
            axi_read(FLAGS_OFFSET, rd, rs);
            `CHECK(rd[5:0], 6'h00);
        end
        // Mask staged until the stop, then inhibits; other flags still signal
        @(posedge aclk);
        cond <= 6'h01;
        wait_int(1'b0);
        axi_write(MASK_OFFSET, 32'h0000_0001, rs);
        hold_int(1'b0);
        do_stop();
        wait_int(1'b1);
        axi_read(LIVE_OFFSET, rd, rs);
        `CHECK(rd[13:8], 6'h01);
        `CHECK(rd[5:0], 6'h01);
        @(posedge aclk);
        cond <= 6'h05;
        wait_int(1'b0);
        @(posedge aclk);
        cond <= 6'h01;
        axi_read(FLAGS_OFFSET, rd, rs);
        do_stop();
        wait_int(1'b1);
        axi_write(MASK_OFFSET, 32'h0000_0000, rs);
        hold_int(1'b1);
        do_stop();
        wait_int(1'b0);
        @(posedge aclk);
        cond <= 6'h00;
        axi_read(FLAGS_OFFSET, rd, rs);
        do_stop();
        wait_int(1'b1);
        // Each select bit: held until the stop, then applied and read back
        for (i = 2; i >= 0; i--) begin
            ctl = 3'(1 << i);
            axi_write(CONTROL_OFFSET, {29'h0, ctl}, rs);
            repeat (20) @(posedge aclk);
            #1;
            `CHECK(control_out, control_type'(3'(2 << i)));
            do_stop();
            n = 0;
            while (control_out !== control_type'(ctl) && n < ON_LIM) begin
                @(posedge aclk);
                #1;
                n++;
            end
            `CHECK(control_out, control_type'(ctl));
            axi_read(CONTROL_OFFSET, rd, rs);
            `CHECK(rd[2:0], ctl);
        end
        // Fast loss mode now committed: status drops soon after signal returns
        @(posedge aclk);
        cond <= 6'h02;
        wait_int(1'b0);
        @(posedge aclk);
        cond <= 6'h00;
        n = 0;
        #1;
        while (rx_los_status !== 1'b0 && n < ON_LIM) begin
            @(posedge aclk);
            #1;
            n++;
        end
        `CHECK(rx_los_status, 1'b0);
        axi_read(FLAGS_OFFSET, rd, rs);
        do_stop();
        wait_int(1'b1);
        // Write-one clear is staged like a read clear, until the stop
        @(posedge aclk);
        cond <= 6'h08;
        wait_int(1'b0);
        @(posedge aclk);
        cond <= 6'h00;
        axi_write(FLAGS_OFFSET, 32'h0000_0008, rs);
        `CHECK(rs, RESP_OKAY);
        hold_int(1'b0);
        do_stop();
        wait_int(1'b1);
        axi_read(FLAGS_OFFSET, rd, rs);
        `CHECK(rd[5:0], 6'h00);
        report_and_stop();
    end
endmodule : module_flag_mask_timing_test
